// ---- common/sbf_pkg.sv ----
// shared constants for the serial break/idle framing block
package sbf_pkg;
    // frame lengths in bit periods (start + data + stop)
    localparam logic [3:0] FRAME_BITS_8 = 4'ha;
    localparam logic [3:0] FRAME_BITS_9 = 4'hb;
    // default bit period in system clocks
    localparam int         BIT_CLKS_DEF = 16;
    // receive data width
    localparam int         DATA_W       = 9;
    localparam logic [8:0] DATA_CLEAR   = 9'h000;
    // transmitter states
    typedef enum logic [2:0] {
        SBF_IDLE,
        SBF_PREAMBLE,
        SBF_DATA,
        SBF_BREAK,
        SBF_MARK
    } sbf_tx_state_t;
endpackage

// ---- verilog/sbf_core.sv ----
// transmit enable, break and idle framing plus receive break detection
// Operation
// - clearing transmit enable mid-frame lets the shifting frame finish
// - writing send-break one loads a break character
// - break is all zeros, no start or stop, length per frame select
// - break characters repeat while send-break and transmit enable both stay set
// - after break ends, send at least one one bit
// - receive break: start, all-zero data and zero stop bit
// - received break sets framing error and full, clears data
// - idle character is all ones, length per frame select
// - enable rise queues a preamble; a break, or data already held as enable rises on an idle line, goes out before it
// - transmit line returns idle once the frame completes after disable
// - disable then enable mid-frame queues one idle character
`timescale 1ns/1ps
`default_nettype none
module sbf_core #(
    parameter int BIT_CLKS = sbf_pkg::BIT_CLKS_DEF
) (
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    input  wire logic       tx_enable,
    input  wire logic       send_break_bit,
    input  wire logic       frame_nine,
    input  wire logic       tx_load,
    input  wire logic [8:0] tx_data,
    input  wire logic       rx_pin,
    input  wire logic       rx_read,
    output logic            tx_pin,
    output logic            tx_data_empty_flag,
    output logic            tx_complete_flag,
    output logic            framing_error_flag,
    output logic            rx_data_full_flag,
    output logic            rx_active_flag,
    output logic [8:0]      serial_data_register
);
    localparam int CW = $clog2(BIT_CLKS + 1);
    localparam logic [CW-1:0] BIT_LAST = CW'(BIT_CLKS - 1);
    localparam logic [CW-1:0] BIT_HALF = CW'(BIT_CLKS / 2);

    sbf_pkg::sbf_tx_state_t st_q, st_d;
    logic [CW-1:0] bclk_q;
    logic [3:0]    bit_q;
    logic [10:0]   sh_q;
    logic [8:0]    hold_q;
    logic          te_q, pre_q, brk_q;

    // frame length follows the frame select bit
    wire [3:0] frame_len = frame_nine ? sbf_pkg::FRAME_BITS_9 : sbf_pkg::FRAME_BITS_8;
    wire       bit_end   = (bclk_q == BIT_LAST);
    wire       char_end  = bit_end && (bit_q == frame_len - 4'h1);
    wire       te_rise   = tx_enable && !te_q;
    wire       brk_rise  = send_break_bit && !brk_q;
    wire       busy      = (st_q != sbf_pkg::SBF_IDLE);
    // data frame: start 0, data lsb first, stop 1
    wire [10:0] data_frame = frame_nine ? {1'b1, hold_q, 1'b0}
                                        : {2'b11, hold_q[7:0], 1'b0};

    // next transmitter state; break outranks preamble, preamble outranks data
    always_comb
    begin
        st_d = st_q;
        if (!busy || char_end)
        begin
            if (send_break_bit && (tx_enable || brk_rise))
                st_d = sbf_pkg::SBF_BREAK;
            else if (st_q == sbf_pkg::SBF_BREAK)
                st_d = sbf_pkg::SBF_MARK;
            else if (tx_enable && pre_q)
                st_d = sbf_pkg::SBF_PREAMBLE;
            else if (tx_enable && !tx_data_empty_flag)
                st_d = sbf_pkg::SBF_DATA;
            else
                st_d = sbf_pkg::SBF_IDLE;
        end
        else if (st_q == sbf_pkg::SBF_MARK && bit_end)
            st_d = sbf_pkg::SBF_IDLE;
    end

    wire start_char = (st_d != sbf_pkg::SBF_IDLE) && (!busy || char_end
                      || (st_q == sbf_pkg::SBF_MARK && bit_end));

    // edge history of control bits
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            te_q  <= 1'b0;
            brk_q <= 1'b0;
        end
        else
        begin
            te_q  <= tx_enable;
            brk_q <= send_break_bit;
        end
    end

    // preamble request: set on enable rise, or on re-enable mid-frame
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            pre_q <= 1'b0;
        else if (te_rise)
            pre_q <= 1'b1;
        else if (start_char && st_d == sbf_pkg::SBF_PREAMBLE)
            pre_q <= 1'b0;
    end

    // holding register and data-empty flag; a load wins over the transfer
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            hold_q             <= 9'h000;
            tx_data_empty_flag <= 1'b1;
        end
        else if (tx_load)
        begin
            hold_q             <= tx_data;
            tx_data_empty_flag <= 1'b0;
        end
        else if (start_char && st_d == sbf_pkg::SBF_DATA)
            tx_data_empty_flag <= 1'b1;
    end

    // shifter and bit timing; a disable never aborts the running frame
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_q   <= sbf_pkg::SBF_IDLE;
            bclk_q <= '0;
            bit_q  <= 4'h0;
            sh_q   <= 11'h7ff;
        end
        else
        begin
            st_q <= st_d;
            if (start_char)
            begin
                bclk_q <= '0;
                bit_q  <= 4'h0;
                case (st_d)
                    sbf_pkg::SBF_BREAK: sh_q <= 11'h000;
                    sbf_pkg::SBF_PREAMBLE: sh_q <= 11'h7ff;
                    sbf_pkg::SBF_DATA: sh_q <= data_frame;
                    default: sh_q <= 11'h7ff;
                endcase
            end
            else if (busy)
            begin
                bclk_q <= bit_end ? '0 : bclk_q + 1'b1;
                if (bit_end)
                begin
                    bit_q <= bit_q + 4'h1;
                    sh_q  <= {1'b1, sh_q[10:1]};
                end
            end
            else
                sh_q <= 11'h7ff;
        end
    end

    // line drive and completion flag straight from flops
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tx_pin           <= 1'b1;
            tx_complete_flag <= 1'b1;
        end
        else
        begin
            tx_pin           <= (st_d == sbf_pkg::SBF_IDLE) ? 1'b1
                              : (start_char ? (st_d != sbf_pkg::SBF_BREAK
                                 && st_d != sbf_pkg::SBF_DATA)
                              : (bit_end ? sh_q[1] : sh_q[0]));
            tx_complete_flag <= (st_d == sbf_pkg::SBF_IDLE);
        end
    end

    // receive: pin synchroniser, then mid-bit sampling of a whole frame
    logic          rx_s1_q, rx_s2_q, rx_on_q, rx_zero_q;
    logic [CW-1:0] rclk_q;
    logic [3:0]    rbit_q;
    logic [8:0]    rsh_q;
    wire r_mid  = (rclk_q == BIT_HALF);
    wire r_stop = r_mid && (rbit_q == frame_len - 4'h1);
    wire [8:0] r_data = frame_nine ? rsh_q : {1'b0, rsh_q[8:1]};
    wire r_break = r_stop && rx_zero_q && !rx_s2_q;

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
        end
        else
        begin
            rx_s1_q <= rx_pin;
            rx_s2_q <= rx_s1_q;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rx_on_q   <= 1'b0;
            rx_zero_q <= 1'b1;
            rclk_q    <= '0;
            rbit_q    <= 4'h0;
            rsh_q     <= 9'h000;
        end
        else if (!rx_on_q)
        begin
            rx_on_q   <= !rx_s2_q;
            rx_zero_q <= 1'b1;
            rclk_q    <= '0;
            rbit_q    <= 4'h0;
        end
        else
        begin
            rclk_q <= (rclk_q == BIT_LAST) ? '0 : rclk_q + 1'b1;
            if (rclk_q == BIT_LAST)
                rbit_q <= rbit_q + 4'h1;
            if (r_mid && rbit_q != 4'h0 && !r_stop)
            begin
                rsh_q     <= {rx_s2_q, rsh_q[8:1]};
                rx_zero_q <= rx_zero_q && !rx_s2_q;
            end
            if (r_stop)
                rx_on_q <= 1'b0;
        end
    end

    // receive flags; a new frame's set wins over the software read
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            framing_error_flag   <= 1'b0;
            rx_data_full_flag    <= 1'b0;
            rx_active_flag       <= 1'b0;
            serial_data_register <= sbf_pkg::DATA_CLEAR;
        end
        else
        begin
            rx_active_flag <= rx_on_q;
            if (r_stop)
            begin
                rx_data_full_flag    <= 1'b1;
                framing_error_flag   <= !rx_s2_q;
                serial_data_register <= r_break ? sbf_pkg::DATA_CLEAR : r_data;
            end
            else if (rx_read)
            begin
                rx_data_full_flag  <= 1'b0;
                framing_error_flag <= 1'b0;
            end
        end
    end

    // break line stays low for the first 8 clocks of the frame
    property p_brk_low;
        @(posedge clk_sys) disable iff (!arst_n)
        (start_char && st_d == sbf_pkg::SBF_BREAK) |=> !tx_pin [*8];
    endproperty
    a_brk_low: assert property (p_brk_low) else $error("break not low");

    property p_mark;
        @(posedge clk_sys) disable iff (!arst_n)
        (st_q == sbf_pkg::SBF_BREAK && st_d == sbf_pkg::SBF_MARK) |=> tx_pin;
    endproperty
    a_mark: assert property (p_mark) else $error("no one after break");

    property p_rxbrk;
        @(posedge clk_sys) disable iff (!arst_n)
        r_break |=> framing_error_flag && rx_data_full_flag && serial_data_register == 9'h000;
    endproperty
    a_rxbrk: assert property (p_rxbrk) else $error("break status wrong");

    property p_nabort;
        @(posedge clk_sys) disable iff (!arst_n)
        (busy && !char_end && st_q != sbf_pkg::SBF_MARK) |=> busy;
    endproperty
    a_nabort: assert property (p_nabort) else $error("frame aborted");

    // a send-break request on an idle line starts a break at once
    property p_brk_load;
        @(posedge clk_sys) disable iff (!arst_n)
        (brk_rise && !busy) |=> (st_q == sbf_pkg::SBF_BREAK);
    endproperty
    a_brk_load: assert property (p_brk_load) else $error("break not loaded");

    // preamble keeps the line high
    property p_pre_high;
        @(posedge clk_sys) disable iff (!arst_n)
        (start_char && st_d == sbf_pkg::SBF_PREAMBLE) |=> tx_pin [*8];
    endproperty
    a_pre_high: assert property (p_pre_high) else $error("idle not high");
endmodule // sbf_core
`default_nettype wire

// ---- testbench/sbf_remote.sv ----
// far-end serial transmitter model feeding the block's receive line
`timescale 1ns/1ps
`default_nettype none
module sbf_remote #(
    parameter int BIT_CLKS = 4
) (
    input  wire logic       clk_sys,
    input  wire logic       go,
    input  wire logic       brk,
    input  wire logic [7:0] byte_in,
    output logic            line_out,
    output logic            busy
);
    logic [9:0] frm;
    initial
    begin
        line_out = 1'b1;
        busy     = 1'b0;
    end
    // one 8-bit frame per go pulse, lsb first, then one idle bit before busy drops
    // a break sends the data and stop positions low as well
    always @(posedge clk_sys)
    begin
        if (go && !busy)
        begin
            busy <= 1'b1;
            frm = brk ? 10'h000 : {1'b1, byte_in, 1'b0};
            for (int i = 0; i < 10; i++)
            begin
                line_out <= frm[i];
                repeat (BIT_CLKS) @(posedge clk_sys);
            end
            line_out <= 1'b1;
            repeat (BIT_CLKS) @(posedge clk_sys);
            busy <= 1'b0;
        end
    end
endmodule // sbf_remote
`default_nettype wire

// ---- testbench/sbf_core_test.sv ----
// self-checking bench for the break, idle and framing block
`timescale 1ns/1ps
`default_nettype none
module sbf_core_test;
    localparam int BC = 4; // short bit period keeps the run brief
    logic clk_sys, arst_n, tx_enable, send_break_bit, frame_nine, tx_load, rx_read;
    logic go, brk, busy, tx_pin, empty, cmpl, fe, full, act, full_q;
    logic [8:0] tx_data, rdata;
    logic [7:0] rbyte, b;
    logic [31:0] bits, exp_q[$];
    wire logic rx_line;
    int seed, n_mismatch, cmp_count, hi, w;

    sbf_core #(.BIT_CLKS(BC)) dut (.clk_sys(clk_sys), .arst_n(arst_n),
        .tx_enable(tx_enable), .send_break_bit(send_break_bit), .frame_nine(frame_nine),
        .tx_load(tx_load), .tx_data(tx_data), .rx_pin(rx_line), .rx_read(rx_read),
        .tx_pin(tx_pin), .tx_data_empty_flag(empty), .tx_complete_flag(cmpl),
        .framing_error_flag(fe), .rx_data_full_flag(full), .rx_active_flag(act),
        .serial_data_register(rdata));
    sbf_remote #(.BIT_CLKS(BC)) remote (.clk_sys(clk_sys), .go(go), .brk(brk),
        .byte_in(rbyte), .line_out(rx_line), .busy(busy));

    // free-running system clock, 100 ns period
    always #50 clk_sys = ~clk_sys;

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask

    // count idle cycles up to the first low, then sample nb bits at mid-bit
    task automatic get_frame(input int nb);
        hi = 0;
        bits = '0;
        @(negedge clk_sys);
        while (tx_pin !== 1'b0)
        begin
            hi++;
            if (hi > 400)
            begin
                chk("line fall", 1, 0);
                final_report();
            end
            @(negedge clk_sys);
        end
        @(negedge clk_sys);
        for (int k = 0; k < nb; k++)
        begin
            bits[k] = tx_pin;
            repeat (BC) @(negedge clk_sys);
        end
    endtask

    // holding register must drain within a bounded time
    task automatic wait_empty;
        w = 0;
        while (empty !== 1'b1 && w < 400)
        begin
            @(posedge clk_sys);
            w++;
        end
        if (w >= 400)
        begin
            chk("empty wait", 1, 0);
            final_report();
        end
    endtask

    // received results are paired with the oldest note as the full flag rises
    always @(negedge clk_sys)
    begin
        full_q <= full;
        if (full === 1'b1 && full_q !== 1'b1)
        begin
            if (exp_q.size() == 0)
                chk("rx note", 1, 0);
            else
                chk("rx result", exp_q.pop_front(), {22'h0, fe, rdata});
        end
    end

    initial
    begin
        seed = 54885;
        n_mismatch = 0;
        cmp_count = 0;
        {clk_sys, arst_n, tx_enable, send_break_bit, frame_nine, tx_load, rx_read} = '0;
        {go, brk, full_q} = '0;
        tx_data = '0;
        rbyte = '0;
        repeat (4) @(posedge clk_sys);
        arst_n <= 1'b1;
        // enable rise: idle character ahead of the first data frame
        b = 8'($random(seed));
        @(posedge clk_sys);
        tx_enable <= 1'b1;
        tx_load <= 1'b1;
        tx_data <= {1'b0, b};
        @(posedge clk_sys);
        tx_load <= 1'b0;
        get_frame(10);
        chk("preamble", 1, 32'(hi >= 40 && hi <= 44));
        chk("data frame", {22'h0, 1'b1, b, 1'b0}, bits);
        $display("test preamble done");
        // single and repeated breaks in both frame lengths, then the mark bit
        for (int f = 0; f < 2; f++)
            for (int n = 1; n < 3; n++)
            begin
                @(posedge clk_sys);
                frame_nine <= f[0];
                send_break_bit <= 1'b1;
                fork
                    get_frame(n * (10 + f) + 1);
                    begin
                        repeat (n == 1 ? 8 : (10 + f) * BC + 8) @(posedge clk_sys);
                        send_break_bit <= 1'b0;
                    end
                join
                chk("break bits", 32'h1 << (n * (10 + f)), bits);
            end
        frame_nine <= 1'b0;
        $display("test break done");
        // toggle enable mid-frame: idle character queued before the next message
        b = 8'($random(seed));
        @(posedge clk_sys);
        tx_load <= 1'b1;
        tx_data <= {1'b0, b};
        @(posedge clk_sys);
        tx_load <= 1'b0;
        fork
            get_frame(10);
            begin
                // last byte, empty, enable low then high, next byte
                wait_empty();
                repeat (6) @(posedge clk_sys);
                tx_enable <= 1'b0;
                @(posedge clk_sys);
                tx_enable <= 1'b1;
                rbyte <= 8'($random(seed));
                @(posedge clk_sys);
                tx_load <= 1'b1;
                tx_data <= {1'b0, rbyte};
                @(posedge clk_sys);
                tx_load <= 1'b0;
            end
        join
        chk("frame before toggle", {22'h0, 1'b1, b, 1'b0}, bits);
        get_frame(10);
        // line high from the stop bit through the queued idle character
        chk("queued idle", 1, 32'(hi >= 36 && hi <= 42));
        chk("next frame", {22'h0, 1'b1, rbyte, 1'b0}, bits);
        $display("test idle queue done");
        // disable mid-frame: frame completes, line rests high
        b = 8'($random(seed));
        @(posedge clk_sys);
        tx_load <= 1'b1;
        tx_data <= {1'b0, b};
        @(posedge clk_sys);
        tx_load <= 1'b0;
        fork
            get_frame(10);
            begin
                // disable only after the holding register drains
                wait_empty();
                repeat (8) @(posedge clk_sys);
                tx_enable <= 1'b0;
            end
        join
        chk("frame after disable", {22'h0, 1'b1, b, 1'b0}, bits);
        repeat (60) @(negedge clk_sys);
        chk("idle line", {31'h0, 1'b1}, {31'h0, tx_pin});
        chk("complete", {31'h0, 1'b1}, {31'h0, cmpl});
        $display("test disable done");
        // receive two bytes around a break
        for (int k = 0; k < 3; k++)
        begin
            @(posedge clk_sys);
            rbyte <= 8'($random(seed));
            brk <= (k == 1);
            go <= 1'b1;
            @(posedge clk_sys);
            go <= 1'b0;
            exp_q.push_back(k == 1 ? 32'h200 : {24'h0, rbyte});
            repeat (2) @(posedge clk_sys);
            repeat (4) @(negedge clk_sys);
            chk("rx active", 1, {31'h0, act});
            w = 0;
            while (busy !== 1'b0 && w < 200)
            begin
                @(posedge clk_sys);
                w++;
            end
            if (w >= 200)
            begin
                chk("remote idle", 1, 0);
                final_report();
            end
            repeat (6) @(posedge clk_sys);
            rx_read <= 1'b1;
            @(posedge clk_sys);
            rx_read <= 1'b0;
            repeat (2) @(negedge clk_sys);
            chk("full cleared", 0, {31'h0, full});
        end
        chk("notes left", 0, exp_q.size());
        $display("test receive done");
        final_report();
    end
endmodule // sbf_core_test
`default_nettype wire
